// ===== rtrmc_crc_unit.sv
`include "rtrmc_params.svh"

module rtrmc_crc_unit (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic calc_i,
   input wire logic rf_busy_i,
   input wire logic msb_first_i,
   input wire logic [1:0] preset_sel_i,
   input wire logic data_valid_i,
   input wire logic [7:0] data_i,
   output logic [7:0] result_high_o,
   output logic [7:0] result_low_o
);

   rtrmc_pkg::rtrmc_crc_state_type r;
   rtrmc_pkg::rtrmc_crc_state_type s;

   function automatic logic [15:0] preset_of(input logic [1:0] sel);
      unique case (sel)
         2'h0: preset_of = `RTRMC_PRESET_00;
         2'h1: preset_of = `RTRMC_PRESET_01;
         2'h2: preset_of = `RTRMC_PRESET_10;
         2'h3: preset_of = `RTRMC_PRESET_11;
      endcase
   endfunction

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d,
      input logic msb);
      logic [15:0] v;
      v = c;
      for (int i = 0; i < 8; i++)
      begin
         if (msb)
         begin
            if (v[15] ^ d[7 - i])
               v = {v[14:0], 1'b0} ^ `RTRMC_POLY_MSB;
            else
               v = {v[14:0], 1'b0};
         end
         else
         begin
            if (v[0] ^ d[i])
               v = {1'b0, v[15:1]} ^ `RTRMC_POLY_LSB;
            else
               v = {1'b0, v[15:1]};
         end
      end
      return v;
   endfunction

   function automatic logic [7:0] rev8(input logic [7:0] b);
      for (int i = 0; i < 8; i++)
         rev8[i] = b[7 - i];
   endfunction

   always_comb
   begin
      s = r;
      if (calc_i)
      begin
         // Protocol order is LSB first; the setting only counts off-air
         s.msb = msb_first_i & ~rf_busy_i;
         s.crc = rf_busy_i ? `RTRMC_PRESET_AUTO : preset_of(preset_sel_i);
      end
      else if (data_valid_i)
         s.crc = crc_step(r.crc, data_i, r.msb);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         r <= '0;
      else
         r <= s;
   end

   assign result_high_o = r.msb ? rev8(r.crc[15:8]) : r.crc[15:8];
   assign result_low_o = r.msb ? rev8(r.crc[7:0]) : r.crc[7:0];

   chk_preset_load: assert property (@(posedge clk_i) disable iff (rst_i)
      calc_i && !rf_busy_i |=> r.crc == preset_of($past(preset_sel_i)))
      else $error("CRC preset not loaded from selection");
   chk_auto_preset: assert property (@(posedge clk_i) disable iff (rst_i)
      calc_i && rf_busy_i |=> r.crc == `RTRMC_PRESET_AUTO && !r.msb)
      else $error("CRC preset or order not automatic during RF traffic");
   chk_result_order: assert property (@(posedge clk_i) disable iff (rst_i)
      r.msb |-> result_high_o == rev8(r.crc[15:8]) && result_low_o == rev8(r.crc[7:0]))
      else $error("CRC result bytes not bit reversed");

endmodule

// ===== rtrmc_host_model.sv
// ************************************************************
// Host side of the register port
// ************************************************************
module rtrmc_host_model (
   input wire logic clk_i,
   output logic [5:0] reg_addr_o,
   output logic reg_wr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      reg_addr_o = 6'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
   end

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      // CRC may only be dropped at the lowest rate
      if ((a == 6'h12 || a == 6'h13) && v[6:4] != 3'h0)
         v[7] = 1'b1;
      reg_addr_o = a;
      reg_wdata_o = v;
      reg_wr_o = 1'b1;
      @(negedge clk_i);
      reg_wr_o = 1'b0;
      // Data is not held past the strobe
      reg_wdata_o = ~v;
   endtask

   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      reg_addr_o = a;
      @(negedge clk_i);
      d = reg_rdata_i;
   endtask
endmodule

// ===== rtrmc_mode_regs.sv
`include "rtrmc_params.svh"

module rtrmc_mode_regs (
   input wire logic CLK_SYS_I,
   input wire logic SYS_RST_I,
   input wire logic [5:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic [7:0] REG_WDATA_I,
   output logic [7:0] REG_RDATA_O,
   input wire logic RF_COMM_ACTIVE_I,
   input wire logic RF_FIELD_ON_I,
   input wire logic TX_START_REQ_I,
   output logic TX_START_O,
   input wire logic TX_DATA_I,
   output logic TX_MOD_O,
   output logic TX_CRC_EN_O,
   output logic [3:0] TX_RATE_SEL_O,
   output logic TX_RATE_RSVD_O,
   output logic RX_CRC_EN_O,
   output logic [3:0] RX_RATE_SEL_O,
   output logic RX_RATE_RSVD_O,
   input wire logic AUX_SERIAL_IN_PIN_I,
   output logic AUX_ENVELOPE_N_O,
   output logic AUX_IN_ACTIVE_IRQ_O,
   input wire logic CRC_CALC_CMD_I,
   input wire logic CRC_DATA_VALID_I,
   input wire logic [7:0] CRC_DATA_I,
   output logic [7:0] CRC_RESULT_HIGH_O,
   output logic [7:0] CRC_RESULT_LOW_O,
   input wire logic RX_START_I,
   input wire logic RX_STOP_I,
   input wire logic RX_FRAME_END_I,
   input wire logic [7:0] RX_BIT_COUNT_I,
   input wire logic [7:0] ERROR_FLAGS_I,
   output logic RX_ACTIVE_O,
   output logic RX_DISCARD_O,
   output logic RX_DONE_O,
   output logic FIFO_WR_O,
   output logic [7:0] FIFO_WDATA_O
);

   // ************************************************************
   // State
   // ************************************************************
   localparam rtrmc_pkg::rtrmc_top_state_type TOP_RESET = '{
      gen: `RTRMC_RST_GENERAL,
      tx: `RTRMC_RST_TX,
      rx: `RTRMC_RST_RX,
      rdata: 8'h00,
      aux_s1: 1'b0,
      aux_s2: 1'b0,
      env_n: 1'b1,
      irq: 1'b0,
      tx_pend: 1'b0,
      tx_start: 1'b0,
      tx_mod: 1'b0
   };

   rtrmc_pkg::rtrmc_top_state_type r;
   rtrmc_pkg::rtrmc_top_state_type s;
   logic tx_allowed;
   logic gen_wr;

   function automatic logic [3:0] decode_rate(input logic [2:0] code);
      unique case (code)
         `RTRMC_RATE_106: decode_rate = 4'h1;
         `RTRMC_RATE_212: decode_rate = 4'h2;
         `RTRMC_RATE_424: decode_rate = 4'h4;
         `RTRMC_RATE_848: decode_rate = 4'h8;
         default: decode_rate = 4'h0;
      endcase
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   assign tx_allowed = !r.gen[`RTRMC_GEN_WAIT_FIELD] || RF_FIELD_ON_I;
   assign gen_wr = REG_WR_I && (REG_ADDR_I == `RTRMC_ADDR_GENERAL);

   always_comb
   begin
      s = r;
      s.irq = 1'b0;
      s.tx_start = 1'b0;
      if (REG_WR_I)
      begin
         // Reserved positions always reload their reset value
         unique case (REG_ADDR_I)
            `RTRMC_ADDR_GENERAL:
            begin
               s.gen = (REG_WDATA_I & `RTRMC_WMASK_GENERAL)
                  | (`RTRMC_RST_GENERAL & ~`RTRMC_WMASK_GENERAL);
            end
            `RTRMC_ADDR_TX:
            begin
               s.tx = (REG_WDATA_I & `RTRMC_WMASK_TX)
                  | (`RTRMC_RST_TX & ~`RTRMC_WMASK_TX);
            end
            `RTRMC_ADDR_RX:
            begin
               s.rx = (REG_WDATA_I & `RTRMC_WMASK_RX)
                  | (`RTRMC_RST_RX & ~`RTRMC_WMASK_RX);
            end
            default:
            begin
               s.rdata = r.rdata;
            end
         endcase
      end
      if (gen_wr && (REG_WDATA_I[`RTRMC_GEN_AUX_POL] != r.gen[`RTRMC_GEN_AUX_POL]))
         s.irq = 1'b1;

      unique case (REG_ADDR_I)
         `RTRMC_ADDR_GENERAL: s.rdata = r.gen;
         `RTRMC_ADDR_TX: s.rdata = r.tx;
         `RTRMC_ADDR_RX: s.rdata = r.rx;
         default: s.rdata = 8'h00;
      endcase

      // Pin is asynchronous; only the second stage is decoded
      s.aux_s1 = AUX_SERIAL_IN_PIN_I;
      s.aux_s2 = r.aux_s1;
      s.env_n = r.gen[`RTRMC_GEN_AUX_POL] ? ~r.aux_s2 : r.aux_s2;

      // A request made while the field is off waits instead of being lost
      if ((TX_START_REQ_I || r.tx_pend) && tx_allowed)
      begin
         s.tx_start = 1'b1;
         s.tx_pend = 1'b0;
      end
      else if (TX_START_REQ_I)
         s.tx_pend = 1'b1;

      s.tx_mod = TX_DATA_I ^ r.tx[`RTRMC_TX_INV_MOD];
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SYS_RST_I)
         r <= TOP_RESET;
      else
         r <= s;
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign REG_RDATA_O = r.rdata;
   assign TX_START_O = r.tx_start;
   assign TX_MOD_O = r.tx_mod;
   assign TX_CRC_EN_O = r.tx[`RTRMC_TX_CRC_EN];
   assign RX_CRC_EN_O = r.rx[`RTRMC_RX_CRC_EN];
   assign TX_RATE_SEL_O = decode_rate(r.tx[`RTRMC_TX_RATE_HI:`RTRMC_TX_RATE_LO]);
   assign RX_RATE_SEL_O = decode_rate(r.rx[`RTRMC_RX_RATE_HI:`RTRMC_RX_RATE_LO]);
   assign TX_RATE_RSVD_O = r.tx[`RTRMC_TX_RATE_HI];
   assign RX_RATE_RSVD_O = r.rx[`RTRMC_RX_RATE_HI];
   assign AUX_ENVELOPE_N_O = r.env_n;
   assign AUX_IN_ACTIVE_IRQ_O = r.irq;

   // ************************************************************
   // CRC coprocessor and receive framing
   // ************************************************************
   rtrmc_crc_unit u_crc (
      .clk_i(CLK_SYS_I),
      .rst_i(SYS_RST_I),
      .calc_i(CRC_CALC_CMD_I),
      .rf_busy_i(RF_COMM_ACTIVE_I),
      .msb_first_i(r.gen[`RTRMC_GEN_MSB_FIRST]),
      .preset_sel_i(r.gen[`RTRMC_GEN_PRESET_HI:`RTRMC_GEN_PRESET_LO]),
      .data_valid_i(CRC_DATA_VALID_I),
      .data_i(CRC_DATA_I),
      .result_high_o(CRC_RESULT_HIGH_O),
      .result_low_o(CRC_RESULT_LOW_O)
   );

   rtrmc_rx_ctl u_rx (
      .clk_i(CLK_SYS_I),
      .rst_i(SYS_RST_I),
      .start_i(RX_START_I),
      .stop_i(RX_STOP_I),
      .frame_end_i(RX_FRAME_END_I),
      .bit_count_i(RX_BIT_COUNT_I),
      .ignore_short_i(r.rx[`RTRMC_RX_IGNORE_SHORT]),
      .multi_frame_i(r.rx[`RTRMC_RX_MULTI_FRAME]),
      .error_flags_i(ERROR_FLAGS_I),
      .active_o(RX_ACTIVE_O),
      .discard_o(RX_DISCARD_O),
      .done_o(RX_DONE_O),
      .fifo_wr_o(FIFO_WR_O),
      .fifo_wdata_o(FIFO_WDATA_O)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (SYS_RST_I);

   chk_reset_values: assert property (
      $fell(SYS_RST_I) |-> r.gen == 8'h3F && r.tx == 8'h00 && r.rx == 8'h00)
      else $error("Settings registers not at reset values");

   chk_reserved_fixed: assert property (
      (r.gen & 8'h54) == 8'h14 && (r.tx & 8'h07) == 8'h00 && (r.rx & 8'h03) == 8'h00)
      else $error("Reserved bits changed");

   // A second toggling write right behind may legally stretch the pulse
   chk_polarity_event: assert property (
      gen_wr && (REG_WDATA_I[3] != r.gen[3])
      |=> AUX_IN_ACTIVE_IRQ_O ##1 (!AUX_IN_ACTIVE_IRQ_O || $past(gen_wr)))
      else $error("Polarity change did not raise a one-cycle event");

   chk_event_cause: assert property (
      AUX_IN_ACTIVE_IRQ_O |-> $past(gen_wr) && $changed(r.gen[3]))
      else $error("Aux event without polarity change");

   sequence aux_active_seq;
      (r.gen[3] ? AUX_SERIAL_IN_PIN_I : !AUX_SERIAL_IN_PIN_I) ##1 $stable(r.gen[3])[*2];
   endsequence

   sequence aux_idle_seq;
      (r.gen[3] ? !AUX_SERIAL_IN_PIN_I : AUX_SERIAL_IN_PIN_I) ##1 $stable(r.gen[3])[*2];
   endsequence

   chk_envelope_act: assert property (aux_active_seq |=> !AUX_ENVELOPE_N_O)
      else $error("Envelope not low for active aux input");

   chk_envelope_idle: assert property (aux_idle_seq |=> AUX_ENVELOPE_N_O)
      else $error("Envelope not high for idle aux input");

   chk_field_gate: assert property (
      TX_START_O |-> $past(!r.gen[5] || RF_FIELD_ON_I))
      else $error("Transmission started without RF field");

   sequence held_start_seq;
      TX_START_REQ_I && r.gen[`RTRMC_GEN_WAIT_FIELD] && !RF_FIELD_ON_I
      ##1 (RF_FIELD_ON_I && r.gen[`RTRMC_GEN_WAIT_FIELD]);
   endsequence

   chk_pending_start: assert property (held_start_seq |=> TX_START_O)
      else $error("Held transmission not started once field came up");

   chk_direct_start: assert property (
      TX_START_REQ_I && tx_allowed |=> TX_START_O)
      else $error("Allowed transmission not started");

   chk_invert_mod: assert property (
      1'b1 |=> TX_MOD_O == ($past(TX_DATA_I) ^ $past(r.tx[3])))
      else $error("Transmit modulation inversion wrong");

   chk_rate_decode: assert property (
      r.tx[6:4] == 3'h3 |-> TX_RATE_SEL_O == 4'h8 && !TX_RATE_RSVD_O)
      else $error("Transmit 848 kBd code decoded wrong");

   chk_rate_reserved: assert property (
      r.rx[6] |-> RX_RATE_SEL_O == 4'h0 && RX_RATE_RSVD_O)
      else $error("Reserved receive rate not flagged");

   // ************************************************************
   // Register port checks
   // ************************************************************
   // Reserved positions must come out of the write path, not only the reset
   chk_general_write: assert property (
      gen_wr |=> r.gen == (($past(REG_WDATA_I) & `RTRMC_WMASK_GENERAL) | 8'h14))
      else $error("General settings write did not land");

   chk_tx_write: assert property (
      REG_WR_I && REG_ADDR_I == `RTRMC_ADDR_TX
      |=> r.tx == ($past(REG_WDATA_I) & `RTRMC_WMASK_TX))
      else $error("Transmit settings write did not land");

   chk_rx_write: assert property (
      REG_WR_I && REG_ADDR_I == `RTRMC_ADDR_RX
      |=> r.rx == ($past(REG_WDATA_I) & `RTRMC_WMASK_RX))
      else $error("Receive settings write did not land");

   chk_unmapped_write: assert property (
      REG_WR_I && !(REG_ADDR_I inside {`RTRMC_ADDR_GENERAL, `RTRMC_ADDR_TX, `RTRMC_ADDR_RX})
      |=> $stable(r.gen) && $stable(r.tx) && $stable(r.rx))
      else $error("Unmapped write changed a settings register");

   // Read data trails the address by one clock
   chk_read_tx: assert property (
      REG_ADDR_I == `RTRMC_ADDR_TX |=> REG_RDATA_O == $past(r.tx))
      else $error("Read data does not follow addressed register");

endmodule

// ===== rtrmc_mode_regs_tb.sv
`include "rtrmc_params.svh"

module rtrmc_mode_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] addr;
   logic wr;
   logic [7:0] wdata, rdata, rv, d, ef;
   logic rf_act = 1'b0, field = 1'b0, tx_req = 1'b0, tx_data = 1'b0, aux_pin = 1'b0;
   logic calc = 1'b0, dval = 1'b0, rx_start = 1'b0, rx_stop = 1'b0, fend = 1'b0;
   logic [7:0] cdata = 8'h00, bcnt = 8'h00, eflags = 8'h00;
   logic tx_start, tx_mod, tx_en, tx_rsvd, rx_en, rx_rsvd, env_n, irq;
   logic [3:0] tx_rate, rx_rate;
   logic [7:0] res_h, res_l, fdata;
   logic rx_act, rx_disc, rx_done, fwr;
   logic [7:0] m_reg [3];
   logic [7:0] msk [3] = '{`RTRMC_WMASK_GENERAL, `RTRMC_WMASK_TX, `RTRMC_WMASK_RX};
   logic [15:0] pre [4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};
   logic [15:0] c;
   logic [31:0] seed = 32'h00008E1C;
   logic m, act;
   int bad_count = 0;
   int checks = 0;

   always #5 clk = ~clk;

   rtrmc_host_model rtrmc_host_model_i (.clk_i(clk), .reg_addr_o(addr), .reg_wr_o(wr),
      .reg_wdata_o(wdata), .reg_rdata_i(rdata));

   rtrmc_mode_regs rtrmc_mode_regs_i (.CLK_SYS_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
      .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .RF_COMM_ACTIVE_I(rf_act),
      .RF_FIELD_ON_I(field), .TX_START_REQ_I(tx_req), .TX_START_O(tx_start),
      .TX_DATA_I(tx_data), .TX_MOD_O(tx_mod), .TX_CRC_EN_O(tx_en), .TX_RATE_SEL_O(tx_rate),
      .TX_RATE_RSVD_O(tx_rsvd), .RX_CRC_EN_O(rx_en), .RX_RATE_SEL_O(rx_rate),
      .RX_RATE_RSVD_O(rx_rsvd), .AUX_SERIAL_IN_PIN_I(aux_pin), .AUX_ENVELOPE_N_O(env_n),
      .AUX_IN_ACTIVE_IRQ_O(irq), .CRC_CALC_CMD_I(calc), .CRC_DATA_VALID_I(dval),
      .CRC_DATA_I(cdata), .CRC_RESULT_HIGH_O(res_h), .CRC_RESULT_LOW_O(res_l),
      .RX_START_I(rx_start), .RX_STOP_I(rx_stop), .RX_FRAME_END_I(fend),
      .RX_BIT_COUNT_I(bcnt), .ERROR_FLAGS_I(eflags), .RX_ACTIVE_O(rx_act),
      .RX_DISCARD_O(rx_disc), .RX_DONE_O(rx_done), .FIFO_WR_O(fwr), .FIFO_WDATA_O(fdata));

   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      for (int b = 0; b < 8; b++)
         r[b] = v[7 - b];
      return r;
   endfunction

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   // Writes through the host and mirrors the write in the model
   task automatic put(input int i, input logic [7:0] v);
      logic [7:0] o;
      o = m_reg[i];
      if (i > 0 && v[6:4] != 3'h0)
         v[7] = 1'b1;
      rtrmc_host_model_i.wr(6'h11 + 6'(i), v);
      m_reg[i] = (o & ~msk[i]) | (v & msk[i]);
      if (i == 0)
         chk("irq", 16'(o[3] != m_reg[0][3]), 16'(irq));
   endtask

   task automatic frame(input logic [7:0] n);
      logic dis;
      dis = m_reg[2][3] && n < 8'h04;
      bcnt = n;
      eflags = xs();
      fend = 1'b1;
      @(negedge clk);
      fend = 1'b0;
      chk("discard", 16'(act & dis), 16'(rx_disc));
      chk("fifo_wr", 16'(act & !dis & m_reg[2][2]), 16'(fwr));
      if (act & !dis & m_reg[2][2])
         chk("fifo_data", 16'(eflags), 16'(fdata));
      chk("rx_done", 16'(act & !dis & !m_reg[2][2]), 16'(rx_done));
      act = act & (dis | m_reg[2][2]);
      chk("rx_active", 16'(act), 16'(rx_act));
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #60000;
      bad_count++;
      close_out();
   end

   initial
   begin
      m_reg = '{`RTRMC_RST_GENERAL, `RTRMC_RST_TX, `RTRMC_RST_RX};
      repeat (6) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         rtrmc_host_model_i.rd(6'h11 + 6'(i), rv);
         chk("reset_reg", 16'((i < 3) ? m_reg[i] : 8'h00), 16'(rv));
      end
      chk("env_reset", 16'h0001, 16'(env_n));
      $display("test reset done");
      // ************************************************************
      // Random writes over every rate code
      // ************************************************************
      for (int k = 0; k < 8; k++)
      begin
         for (int i = 0; i < 3; i++)
         begin
            d = xs();
            d[6:4] = 3'(k);
            put(i, d);
            rtrmc_host_model_i.rd(6'h11 + 6'(i), rv);
            chk("reg", 16'(m_reg[i]), 16'(rv));
         end
         chk("tx_crc", 16'(m_reg[1][7]), 16'(tx_en));
         chk("rx_crc", 16'(m_reg[2][7]), 16'(rx_en));
         chk("tx_rate", 16'((k < 4) ? (4'h1 << k) : 4'h0), 16'(tx_rate));
         chk("rx_rate", 16'((k < 4) ? (4'h1 << k) : 4'h0), 16'(rx_rate));
         chk("tx_rsvd", 16'(k >= 4), 16'(tx_rsvd));
         chk("rx_rsvd", 16'(k >= 4), 16'(rx_rsvd));
      end
      rtrmc_host_model_i.wr(6'h10, 8'hFF);
      for (int i = 0; i < 3; i++)
      begin
         rtrmc_host_model_i.rd(6'h11 + 6'(i), rv);
         chk("unmapped_wr", 16'(m_reg[i]), 16'(rv));
      end
      $display("test registers done");
      // ************************************************************
      // Aux input polarity and transmit path
      // ************************************************************
      for (int p = 0; p < 4; p++)
      begin
         put(0, (m_reg[0] & 8'hF7) | (8'(p[1]) << 3));
         aux_pin = p[0];
         repeat (4) @(negedge clk);
         chk("env_n", 16'(!(aux_pin == m_reg[0][3])), 16'(env_n));
      end
      put(0, m_reg[0] | 8'h20);
      tx_req = 1'b1;
      @(negedge clk);
      tx_req = 1'b0;
      chk("tx_start_nofield", 16'h0000, 16'(tx_start));
      field = 1'b1;
      @(negedge clk);
      chk("tx_start", 16'h0001, 16'(tx_start));
      @(negedge clk);
      chk("tx_start_end", 16'h0000, 16'(tx_start));
      field = 1'b0;
      put(0, m_reg[0] & 8'hDF);
      tx_req = 1'b1;
      @(negedge clk);
      tx_req = 1'b0;
      chk("tx_start_nowait", 16'h0001, 16'(tx_start));
      for (int t = 0; t < 8; t++)
      begin
         if (t[0] == 1'b0)
            put(1, {m_reg[1][7:4], t[1], 3'h0});
         tx_data = xs() > 8'h7F;
         @(negedge clk);
         chk("tx_mod", 16'(tx_data ^ m_reg[1][3]), 16'(tx_mod));
      end
      $display("test transmit done");
      // ************************************************************
      // CRC presets, bit order and the RF override
      // ************************************************************
      for (int s = 0; s < 16; s++)
      begin
         put(0, (m_reg[0] & 8'h7C) | (8'(s[2]) << 7) | 8'(s[1:0]));
         rf_act = s[3];
         m = s[3] ? 1'b0 : s[2];
         c = s[3] ? `RTRMC_PRESET_AUTO : pre[s[1:0]];
         calc = 1'b1;
         @(negedge clk);
         calc = 1'b0;
         chk("crc_preset", m ? {rev8(c[15:8]), rev8(c[7:0])} : c,
            {res_h, res_l});
         cdata = xs();
         dval = 1'b1;
         @(negedge clk);
         dval = 1'b0;
         c = m ? c ^ {cdata, 8'h00} : c ^ {8'h00, cdata};
         for (int b = 0; b < 8; b++)
            c = m ? ((c << 1) ^ (c[15] ? 16'h1021 : 16'h0000))
                  : ((c >> 1) ^ (c[0] ? 16'h8408 : 16'h0000));
         chk("crc_byte", m ? {rev8(c[15:8]), rev8(c[7:0])} : c,
            {res_h, res_l});
      end
      rf_act = 1'b0;
      $display("test crc done");
      // ************************************************************
      // Receive framing
      // ************************************************************
      act = 1'b0;
      frame(8'h08);
      put(2, 8'h0C);
      rx_start = 1'b1;
      @(negedge clk);
      rx_start = 1'b0;
      act = 1'b1;
      chk("rx_start", 16'h0001, 16'(rx_act));
      frame(8'h03);
      frame(8'h04);
      frame(8'h08);
      rx_stop = 1'b1;
      @(negedge clk);
      rx_stop = 1'b0;
      act = 1'b0;
      chk("rx_stop", 16'h0000, 16'(rx_act));
      put(2, 8'h00);
      rx_start = 1'b1;
      @(negedge clk);
      rx_start = 1'b0;
      act = 1'b1;
      frame(8'h02);
      frame(8'h08);
      put(2, 8'h04);
      rx_start = 1'b1;
      @(negedge clk);
      rx_start = 1'b0;
      put(2, 8'h00);
      @(negedge clk);
      chk("rx_multi_clear", 16'h0000, 16'(rx_act));
      $display("test receive done");
      close_out();
   end
endmodule

// ===== rtrmc_params.svh
`ifndef RTRMC_PARAMS_SVH
`define RTRMC_PARAMS_SVH

// ************************************************************
// Register offsets on the register port
// ************************************************************
`define RTRMC_ADDR_GENERAL 6'h11
`define RTRMC_ADDR_TX 6'h12
`define RTRMC_ADDR_RX 6'h13

// ************************************************************
// Reset values and writable bit masks
// ************************************************************
`define RTRMC_RST_GENERAL (8'h3F)
`define RTRMC_RST_TX (8'h00)
`define RTRMC_RST_RX (8'h00)
`define RTRMC_WMASK_GENERAL (8'hAB)
`define RTRMC_WMASK_TX (8'hF8)
`define RTRMC_WMASK_RX (8'hFC)

// ************************************************************
// Field positions
// ************************************************************
`define RTRMC_GEN_MSB_FIRST 7
`define RTRMC_GEN_WAIT_FIELD 5
`define RTRMC_GEN_AUX_POL 3
`define RTRMC_GEN_PRESET_HI 1
`define RTRMC_GEN_PRESET_LO 0
`define RTRMC_TX_CRC_EN 7
`define RTRMC_TX_RATE_HI 6
`define RTRMC_TX_RATE_LO 4
`define RTRMC_TX_INV_MOD 3
`define RTRMC_RX_CRC_EN 7
`define RTRMC_RX_RATE_HI 6
`define RTRMC_RX_RATE_LO 4
`define RTRMC_RX_IGNORE_SHORT 3
`define RTRMC_RX_MULTI_FRAME 2

// ************************************************************
// Bit rate codes
// ************************************************************
`define RTRMC_RATE_106 3'h0
`define RTRMC_RATE_212 3'h1
`define RTRMC_RATE_424 3'h2
`define RTRMC_RATE_848 3'h3

// ************************************************************
// CRC presets and polynomials
// ************************************************************
`define RTRMC_PRESET_00 16'h0000
`define RTRMC_PRESET_01 16'h6363
`define RTRMC_PRESET_10 16'hA671
`define RTRMC_PRESET_11 16'hFFFF
`define RTRMC_PRESET_AUTO 16'h6363
`define RTRMC_POLY_MSB 16'h1021
`define RTRMC_POLY_LSB 16'h8408

// ************************************************************
// Receive framing
// ************************************************************
`define RTRMC_RX_MIN_BITS 8'h04

`endif

// ===== rtrmc_pkg.sv
package rtrmc_pkg;

   typedef struct packed {
      logic [7:0] gen;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [7:0] rdata;
      logic aux_s1;
      logic aux_s2;
      logic env_n;
      logic irq;
      logic tx_pend;
      logic tx_start;
      logic tx_mod;
   } rtrmc_top_state_type;

   typedef struct packed {
      logic [15:0] crc;
      logic msb;
   } rtrmc_crc_state_type;

   typedef struct packed {
      logic active;
      logic multi_prev;
      logic discard;
      logic done;
      logic fifo_wr;
      logic [7:0] fifo_data;
   } rtrmc_rx_state_type;

endpackage

// ===== rtrmc_rx_ctl.sv
`include "rtrmc_params.svh"

module rtrmc_rx_ctl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic frame_end_i,
   input wire logic [7:0] bit_count_i,
   input wire logic ignore_short_i,
   input wire logic multi_frame_i,
   input wire logic [7:0] error_flags_i,
   output logic active_o,
   output logic discard_o,
   output logic done_o,
   output logic fifo_wr_o,
   output logic [7:0] fifo_wdata_o
);

   rtrmc_pkg::rtrmc_rx_state_type r;
   rtrmc_pkg::rtrmc_rx_state_type s;
   logic short_frame;

   assign short_frame = bit_count_i < `RTRMC_RX_MIN_BITS;

   always_comb
   begin
      s = r;
      s.discard = 1'b0;
      s.done = 1'b0;
      s.fifo_wr = 1'b0;
      s.multi_prev = multi_frame_i;
      if (start_i)
         s.active = 1'b1;
      if (r.active && frame_end_i)
      begin
         if (short_frame && ignore_short_i)
            s.discard = 1'b1;
         else if (multi_frame_i)
         begin
            s.fifo_wr = 1'b1;
            s.fifo_data = error_flags_i;
         end
         else
         begin
            s.active = 1'b0;
            s.done = 1'b1;
         end
      end
      // Clearing multi-frame mode or another command ends reception
      if (stop_i || (r.active && r.multi_prev && !multi_frame_i))
         s.active = 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         r <= '0;
      else
         r <= s;
   end

   assign active_o = r.active;
   assign discard_o = r.discard;
   assign done_o = r.done;
   assign fifo_wr_o = r.fifo_wr;
   assign fifo_wdata_o = r.fifo_data;

   sequence frame_in_seq;
      r.active && frame_end_i && !stop_i && !start_i && !(r.multi_prev && !multi_frame_i);
   endsequence

   chk_short_discard: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_in_seq ##0 (short_frame && ignore_short_i) |=> discard_o && active_o && !fifo_wr_o)
      else $error("Short frame not discarded with receiver kept active");
   chk_single_end: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_in_seq ##0 (!(short_frame && ignore_short_i) && !multi_frame_i)
      |=> done_o && !active_o)
      else $error("Receiver not stopped after single frame");
   chk_multi_errbyte: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_in_seq ##0 (!(short_frame && ignore_short_i) && multi_frame_i && r.multi_prev)
      |=> fifo_wr_o && active_o && fifo_wdata_o == $past(error_flags_i))
      else $error("Error byte not appended in multi-frame mode");

endmodule
